// ==== hdl/mcr_pkg.sv ====
/*
 * constants shared by the collision window / retry limit block:
 * register offsets, field positions, reset values and bus codes.
 * assumes a 32-bit AHB-Lite register bus with byte addressing.
 */
package mcr_pkg;

    // ==========================================================
    // register offsets (low address byte)
    // ==========================================================
    localparam logic [7:0]  MCR_OFF_CFG   = 8'h00; // config register
    localparam logic [7:0]  MCR_OFF_CLR   = 8'h04; // clear alias
    localparam logic [7:0]  MCR_OFF_SET   = 8'h08; // set alias
    localparam logic [7:0]  MCR_OFF_INV   = 8'h0c; // invert alias
    localparam logic [7:0]  MCR_OFF_STAT  = 8'h10; // transmit status

    // ==========================================================
    // field layout and reset values
    // ==========================================================
    localparam int          MCR_CWIN_LSB  = 8;     // window field low bit
    localparam int          MCR_CWIN_W    = 6;     // window field width
    localparam int          MCR_RETRY_LSB = 0;     // retry field low bit
    localparam int          MCR_RETRY_W   = 4;     // retry field width
    localparam logic [5:0]  MCR_CWIN_RST  = 6'h37; // 55 frame bytes
    localparam logic [3:0]  MCR_RETRY_RST = 4'hf;  // fifteen retries
    localparam logic [31:0] MCR_CFG_MASK  = 32'h00003f0f; // implemented bits
    localparam logic [31:0] MCR_CFG_RST   = 32'h0000370f; // config after reset

    // status register bit positions
    localparam int          MCR_ST_INWIN  = 8;     // frame inside window
    localparam int          MCR_ST_EXCESS = 9;     // sticky: frame aborted
    localparam int          MCR_ST_LATE   = 10;    // sticky: late collision

    // ==========================================================
    // bus codes
    // ==========================================================
    localparam logic [2:0]  MCR_SIZE_BYTE = 3'h0;  // 8-bit access
    localparam logic [2:0]  MCR_SIZE_HALF = 3'h1;  // 16-bit access
    localparam logic [2:0]  MCR_SIZE_WORD = 3'h2;  // 32-bit access

    // register write operation
    typedef enum logic [2:0] {
        MCR_OP_NONE,
        MCR_OP_WRITE,
        MCR_OP_CLR,
        MCR_OP_SET,
        MCR_OP_INV,
        MCR_OP_STCLR
    } mcr_op_t;

endpackage

// ==== hdl/mcr_tx_tracker.sv ====
/*
 * per-frame collision tracker: counts frame bytes from the start of
 * transmission and attempts per frame, decides retry or abort.
 * assumes strobes from the transmit engine, synchronous to clk.
 */
module mcr_tx_tracker
    import mcr_pkg::*;
#(
    parameter int CNT_W = 7                      // byte counter width
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   nrst,
    // configuration
    input  wire logic [MCR_CWIN_W-1:0]  window_len,
    input  wire logic [MCR_RETRY_W-1:0] retry_limit,
    // transmit engine strobes
    input  wire logic                   tx_start,
    input  wire logic                   tx_byte,
    input  wire logic                   collision,
    input  wire logic                   tx_done,
    // results
    output logic                        in_window,
    output logic [MCR_RETRY_W-1:0]      attempts,
    output logic                        retry_pulse,
    output logic                        abort_pulse,
    output logic                        late_pulse
);

    // ==========================================================
    // state
    // ==========================================================
    logic                   active;       // frame on the wire
    logic [CNT_W-1:0]       bytes;        // bytes since frame start
    logic                   next_active;
    logic [CNT_W-1:0]       next_bytes;
    logic [MCR_RETRY_W-1:0] next_attempts;
    logic                   next_retry;
    logic                   next_abort;
    logic                   next_late;

    // window is open while fewer bytes than the window length went out
    assign in_window = active && (bytes < CNT_W'(window_len));

    // next state: byte count, attempt count, retry decision
    always_comb begin
        next_active   = active;
        next_bytes    = bytes;
        next_attempts = attempts;
        next_retry    = 1'b0;
        next_abort    = 1'b0;
        next_late     = 1'b0;
        // preamble and delimiter bytes count from the very start
        if (tx_start) begin
            next_active = 1'b1;
            next_bytes  = tx_byte ? CNT_W'(1) : '0;
        end else if (active && tx_byte && (bytes != '1)) begin
            next_bytes = bytes + CNT_W'(1);
        end
        if (active && collision) begin
            next_active = 1'b0;
            if (!in_window) begin
                // collision past the slot time: not retried here
                next_late = 1'b1;
            end else if (attempts >= retry_limit) begin
                // attempt budget spent: abort for excessive collisions
                next_abort    = 1'b1;
                next_attempts = '0;
            end else begin
                next_retry    = 1'b1;
                next_attempts = attempts + MCR_RETRY_W'(1);
            end
        end else if (active && tx_done) begin
            // frame went out cleanly: fresh budget for the next one
            next_active   = 1'b0;
            next_attempts = '0;
        end
    end

    // registers only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            active      <= 1'b0;
            bytes       <= '0;
            attempts    <= '0;
            retry_pulse <= 1'b0;
            abort_pulse <= 1'b0;
            late_pulse  <= 1'b0;
        end else begin
            active      <= next_active;
            bytes       <= next_bytes;
            attempts    <= next_attempts;
            retry_pulse <= next_retry;
            abort_pulse <= next_abort;
            late_pulse  <= next_late;
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    AST_ABORT_AT_LIMIT: assert property (@(posedge clk) disable iff (!nrst)
        (active && collision && in_window && attempts >= retry_limit) |=> abort_pulse && !retry_pulse)
        else $error("abort missing at retry limit");
    AST_RETRY_BELOW: assert property (@(posedge clk) disable iff (!nrst)
        (active && collision && in_window && attempts < retry_limit)
        |=> retry_pulse && attempts == $past(attempts) + 4'h1)
        else $error("retry missing below limit");
    AST_COUNT_FROM_START: assert property (@(posedge clk) disable iff (!nrst)
        (tx_start && tx_byte) ##1 (!tx_byte && !tx_start)[*2] |-> bytes == CNT_W'(1))
        else $error("first frame byte not counted");
    COV_ABORT: cover property (@(posedge clk) disable iff (!nrst) abort_pulse);
    COV_RETRY: cover property (@(posedge clk) disable iff (!nrst) retry_pulse ##[1:200] tx_done);

endmodule

// ==== hdl/mcr_top.sv ====
/*
 * collision window / retry limit configuration of an ethernet mac
 * transmitter, with its AHB-Lite register slave and frame tracker.
 * assumes one AHB-Lite master, zero wait states, CLK at 100 MHz.
 */
module mcr_top
    import mcr_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        NRST,
    // ahb-lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // transmit engine strobes
    input  wire logic        TX_START,
    input  wire logic        TX_BYTE,
    input  wire logic        COLLISION,
    input  wire logic        TX_DONE,
    // transmit decisions
    output logic             IN_WINDOW,
    output logic             RETRY,
    output logic             EXCESS_ABORT,
    output logic             LATE_COLLISION
);

    // ==========================================================
    // bus data phase state
    // ==========================================================
    logic        dp_wr;          // write data phase pending
    mcr_op_t     dp_op;          // operation of that write
    logic [31:0] dp_mask;        // active byte lanes of that write
    logic        next_dp_wr;
    mcr_op_t     next_dp_op;
    logic [31:0] next_dp_mask;
    logic [31:0] next_hrdata;

    // ==========================================================
    // register state
    // ==========================================================
    logic [31:0] cfg;            // collision_retry_config_reg
    logic        excess;         // sticky: frame aborted
    logic        late;           // sticky: late collision
    logic [31:0] next_cfg;
    logic        next_excess;
    logic        next_late;

    // tracker results
    logic [MCR_RETRY_W-1:0] attempts;     // attempts of current frame
    logic                   abort_pulse;  // frame aborted
    logic                   late_pulse;   // collision past window
    logic                   in_win;       // window open

    // decoded fields
    logic [MCR_CWIN_W-1:0]  collision_window_len;
    logic [MCR_RETRY_W-1:0] retry_limit;
    assign collision_window_len = cfg[MCR_CWIN_LSB +: MCR_CWIN_W];
    assign retry_limit          = cfg[MCR_RETRY_LSB +: MCR_RETRY_W];

    // address phase qualifiers
    logic        addr_ok;        // a transfer is taken this edge
    logic        size_ok;        // halfword or word access
    logic [7:0]  offs;           // decoded offset
    logic [31:0] lane_mask;      // lanes covered by the access
    logic [31:0] status_word;    // status register image
    assign addr_ok   = HSEL && HTRANS[1] && HREADY;
    assign size_ok   = (HSIZE == MCR_SIZE_HALF) || (HSIZE == MCR_SIZE_WORD);
    assign offs      = HADDR[7:0];
    assign lane_mask = (HSIZE == MCR_SIZE_WORD) ? 32'hffffffff :
                       (HADDR[1] ? 32'hffff0000 : 32'h0000ffff);

    // status image: attempts, window, sticky flags
    always_comb begin
        status_word                   = '0;
        status_word[MCR_RETRY_W-1:0]  = attempts;
        status_word[MCR_ST_INWIN]     = in_win;
        status_word[MCR_ST_EXCESS]    = excess;
        status_word[MCR_ST_LATE]      = late;
    end

    // zero wait states, always OKAY
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    // ==========================================================
    // address phase decode and read data
    // ==========================================================
    always_comb begin
        next_dp_wr   = 1'b0;
        next_dp_op   = MCR_OP_NONE;
        next_dp_mask = '0;
        next_hrdata  = '0;
        // byte accesses fall through with no effect and zero data
        if (addr_ok && size_ok) begin
            if (HWRITE) begin
                next_dp_wr   = 1'b1;
                next_dp_mask = lane_mask;
                case (offs)
                    MCR_OFF_CFG:  next_dp_op = MCR_OP_WRITE;
                    MCR_OFF_CLR:  next_dp_op = MCR_OP_CLR;
                    MCR_OFF_SET:  next_dp_op = MCR_OP_SET;
                    MCR_OFF_INV:  next_dp_op = MCR_OP_INV;
                    MCR_OFF_STAT: next_dp_op = MCR_OP_STCLR;
                    default:      next_dp_op = MCR_OP_NONE;
                endcase
            end else begin
                // config reads see a write finishing in this very cycle; status reads show the flags before it
                case (offs)
                    MCR_OFF_CFG, MCR_OFF_CLR, MCR_OFF_SET, MCR_OFF_INV:
                        next_hrdata = next_cfg & MCR_CFG_MASK;
                    MCR_OFF_STAT:
                        next_hrdata = status_word;
                    default:
                        next_hrdata = '0;
                endcase
            end
        end
    end

    // registers only
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            dp_wr   <= 1'b0;
            dp_op   <= MCR_OP_NONE;
            dp_mask <= '0;
            HRDATA  <= '0;
        end else begin
            dp_wr   <= next_dp_wr;
            dp_op   <= next_dp_op;
            dp_mask <= next_dp_mask;
            HRDATA  <= next_hrdata;
        end
    end

    // ==========================================================
    // register write data phase
    // ==========================================================
    always_comb begin
        logic [31:0] wbits;
        wbits       = HWDATA & dp_mask & MCR_CFG_MASK;
        next_cfg    = cfg;
        next_excess = excess;
        next_late   = late;
        if (dp_wr) begin
            case (dp_op)
                MCR_OP_WRITE: next_cfg = (cfg & ~(dp_mask & MCR_CFG_MASK)) | wbits;
                MCR_OP_CLR:   next_cfg = cfg & ~wbits;
                MCR_OP_SET:   next_cfg = cfg | wbits;
                MCR_OP_INV:   next_cfg = cfg ^ wbits;
                MCR_OP_STCLR: begin
                    // write one clears a sticky flag
                    if (HWDATA[MCR_ST_EXCESS] && dp_mask[MCR_ST_EXCESS]) begin
                        next_excess = 1'b0;
                    end
                    if (HWDATA[MCR_ST_LATE] && dp_mask[MCR_ST_LATE]) begin
                        next_late = 1'b0;
                    end
                end
                default:      next_cfg = cfg;
            endcase
        end
        // a new event wins over a clear in the same cycle
        if (abort_pulse) begin
            next_excess = 1'b1;
        end
        if (late_pulse) begin
            next_late = 1'b1;
        end
    end

    // registers only
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            cfg    <= MCR_CFG_RST;
            excess <= 1'b0;
            late   <= 1'b0;
        end else begin
            cfg    <= next_cfg;
            excess <= next_excess;
            late   <= next_late;
        end
    end

    // ==========================================================
    // frame tracker
    // ==========================================================
    mcr_tx_tracker #(
        .CNT_W       (7)
    ) u_tracker (
        .clk         (CLK),
        .nrst        (NRST),
        .window_len  (collision_window_len),
        .retry_limit (retry_limit),
        .tx_start    (TX_START),
        .tx_byte     (TX_BYTE),
        .collision   (COLLISION),
        .tx_done     (TX_DONE),
        .in_window   (in_win),
        .attempts    (attempts),
        .retry_pulse (RETRY),
        .abort_pulse (abort_pulse),
        .late_pulse  (late_pulse)
    );

    assign IN_WINDOW      = in_win;
    assign EXCESS_ABORT   = abort_pulse;
    assign LATE_COLLISION = late_pulse;

    // ==========================================================
    // checks
    // ==========================================================
    AST_RESET_FIELDS: assert property (@(posedge CLK)
        $rose(NRST) |-> cfg[13:8] == 6'h37)
        else $error("window field reset value wrong");
    AST_RESET_RETRY: assert property (@(posedge CLK)
        $rose(NRST) |-> cfg[3:0] == 4'hf)
        else $error("retry field reset value wrong");
    AST_UNUSED_ZERO: assert property (@(posedge CLK) disable iff (!NRST)
        $past(addr_ok && !HWRITE) |-> (HRDATA & 32'hffffc0f0) == 32'h0)
        else $error("unimplemented bits read nonzero");
    AST_BYTE_IGNORED: assert property (@(posedge CLK) disable iff (!NRST)
        (addr_ok && HWRITE && HSIZE == 3'h0) ##1 !dp_wr |=> $stable(cfg))
        else $error("byte write changed register");
    AST_SET_ALIAS: assert property (@(posedge CLK) disable iff (!NRST)
        (addr_ok && HWRITE && HSIZE == 3'h2 && offs == 8'h08)
        ##1 1'b1 |=> cfg == ($past(cfg) | ($past(HWDATA) & 32'h00003f0f)))
        else $error("set alias wrong");
    AST_CLR_ALIAS: assert property (@(posedge CLK) disable iff (!NRST)
        (addr_ok && HWRITE && HSIZE == 3'h2 && offs == 8'h04)
        ##1 1'b1 |=> cfg == ($past(cfg) & ~$past(HWDATA)))
        else $error("clear alias wrong");
    AST_INV_ALIAS: assert property (@(posedge CLK) disable iff (!NRST)
        (addr_ok && HWRITE && HSIZE == 3'h2 && offs == 8'h0c)
        ##1 1'b1 |=> cfg == ($past(cfg) ^ ($past(HWDATA) & 32'h00003f0f)))
        else $error("invert alias wrong");
    AST_HALF_WRITE: assert property (@(posedge CLK) disable iff (!NRST)
        (addr_ok && HWRITE && HSIZE == 3'h1 && HADDR[7:0] == 8'h00)
        ##1 1'b1 |=> cfg[13:0] == ($past(HWDATA[13:0]) & 14'h3f0f))
        else $error("halfword write not taken");
    AST_WINDOW_FIELD: assert property (@(posedge CLK) disable iff (!NRST)
        collision_window_len == cfg[13:8] && retry_limit == cfg[3:0])
        else $error("field positions wrong");
    AST_EXCESS_STICKY: assert property (@(posedge CLK) disable iff (!NRST)
        EXCESS_ABORT |=> excess)
        else $error("abort not recorded");
    COV_HALF_READ: cover property (@(posedge CLK) disable iff (!NRST)
        addr_ok && !HWRITE && HSIZE == 3'h1);
    COV_BYTE_WRITE: cover property (@(posedge CLK) disable iff (!NRST)
        addr_ok && HWRITE && HSIZE == 3'h0);

endmodule

// ==== sim/mcr_medium_model.sv ====
/*
 * partner model: the transmit engine and medium that drive the
 * frame strobes (start, bytes, collision or clean end).
 * assumes commands from the bench given just after a clock edge.
 */
module mcr_medium_model (
    // clock
    input  wire logic       clk,
    // command from the bench
    input  wire logic       go,
    input  wire logic [6:0] nbytes,
    input  wire logic       coll,
    // strobes to the block
    output logic            tx_start,
    output logic            tx_byte,
    output logic            collision,
    output logic            tx_done,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================
    // frame sequencer
    // ========================================
    // bytes start with the start strobe, so preamble bytes count
    initial begin
        tx_start  = 1'b0;
        tx_byte   = 1'b0;
        collision = 1'b0;
        tx_done   = 1'b0;
        busy      = 1'b0;
        forever begin
            @(posedge clk);
            if (go) begin
                busy     <= 1'b1;
                tx_start <= 1'b1;
                tx_byte  <= 1'b1;
                @(posedge clk);
                tx_start <= 1'b0;
                repeat (int'(nbytes) - 1) @(posedge clk);
                // end the attempt: collision or clean finish
                tx_byte   <= 1'b0;
                collision <= coll;
                tx_done   <= ~coll;
                @(posedge clk);
                collision <= 1'b0;
                tx_done   <= 1'b0;
                busy      <= 1'b0;
            end
        end
    end
endmodule

// ==== sim/tb_mac_collision_retry_config.sv ====
/*
 * self-checking bench: register access over AHB-Lite and
 * collision decisions driven by the medium model.
 * assumes the zero wait state slave of mcr_top.
 */
module tb_mac_collision_retry_config
    import mcr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================
    // signals
    // ========================================
    logic        clk = 1'b0;      // 100 MHz clock
    logic        nrst = 1'b0;     // reset, active low
    logic        hsel = 1'b0;     // bus select
    logic [31:0] haddr = '0;      // bus address
    logic [1:0]  htrans = 2'h0;   // transfer kind
    logic        hwrite = 1'b0;   // write flag
    logic [2:0]  hsize = 3'h2;    // access size
    logic [31:0] hwdata = '0;     // write data
    logic [31:0] hrdata;          // read data
    logic        hreadyout;       // slave ready
    logic        hresp;           // slave response
    logic        tx_start, tx_byte, collision, tx_done, busy;
    logic        go = 1'b0;       // frame command
    logic [6:0]  nb = 7'h01;      // bytes per frame
    logic        cl = 1'b0;       // end in collision
    logic        in_win, retry, abort, late;
    logic [31:0] n_ret = '0;      // retry pulses seen
    logic [31:0] n_abt = '0;      // abort pulses seen
    logic [31:0] n_late = '0;     // late pulses seen
    logic [31:0] n_win = '0;      // window-open cycles seen
    int          err_total = 0;   // mismatches
    int          n_checks = 0;    // comparisons

    always #5 clk = ~clk;

    // pulse counters
    always @(posedge clk) begin
        n_ret  <= n_ret + 32'(retry);
        n_abt  <= n_abt + 32'(abort);
        n_late <= n_late + 32'(late);
        n_win  <= n_win + 32'(in_win);
    end

    // ========================================
    // design and partner
    // ========================================
    mcr_top i_dut (
        .CLK(clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
        .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .TX_START(tx_start),
        .TX_BYTE(tx_byte), .COLLISION(collision), .TX_DONE(tx_done),
        .IN_WINDOW(in_win), .RETRY(retry), .EXCESS_ABORT(abort),
        .LATE_COLLISION(late)
    );

    mcr_medium_model i_med (
        .clk(clk), .go(go), .nbytes(nb), .coll(cl),
        .tx_start(tx_start), .tx_byte(tx_byte),
        .collision(collision), .tx_done(tx_done), .busy(busy)
    );

    // ========================================
    // shared tasks
    // ========================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one single transfer; address phase held until ready
    task automatic acc(input logic w, input logic [7:0] a, input logic [2:0] sz,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        hsize  <= sz;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz);
        logic [31:0] rd;
        acc(1'b1, a, sz, d, rd);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        acc(1'b0, a, MCR_SIZE_WORD, 32'h0, rd);
        chk(rd, exp);
        chk({31'h0, hresp}, 32'h0);
    endtask

    // one attempt of n bytes, ending in collision when c
    task automatic frame(input int n, input logic c);
        go <= 1'b1;
        nb <= 7'(n);
        cl <= c;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        while (busy) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask

    // ========================================
    // scenarios
    // ========================================
    task automatic t_reset();
        rdc(MCR_OFF_CFG, 32'h0000370f);
        rdc(8'h14, 32'h0);
    endtask

    task automatic t_word();
        wr(MCR_OFF_CFG, 32'hffffffff, MCR_SIZE_WORD);
        rdc(MCR_OFF_CFG, 32'h00003f0f);
    endtask

    task automatic t_alias();
        wr(MCR_OFF_CFG, 32'h00002a05, MCR_SIZE_WORD);
        wr(MCR_OFF_CLR, 32'h00000a01, MCR_SIZE_WORD);
        rdc(MCR_OFF_CFG, 32'h00002004);
        wr(MCR_OFF_SET, 32'h00001108, MCR_SIZE_WORD);
        rdc(MCR_OFF_CLR, 32'h0000310c);
        wr(MCR_OFF_INV, 32'h00003f0f, MCR_SIZE_WORD);
        rdc(MCR_OFF_CFG, 32'h00000e03);
    endtask

    task automatic t_sizes();
        logic [31:0] rd;
        wr(MCR_OFF_CFG, 32'h00001234, MCR_SIZE_HALF);
        rdc(MCR_OFF_CFG, 32'h00001204);
        wr(MCR_OFF_SET, 32'h00000001, MCR_SIZE_HALF);
        rdc(MCR_OFF_CFG, 32'h00001205);
        wr(MCR_OFF_CFG, 32'h000000ff, MCR_SIZE_BYTE);
        wr(MCR_OFF_SET, 32'h00003f0f, MCR_SIZE_BYTE);
        wr(MCR_OFF_INV, 32'h00003f0f, MCR_SIZE_BYTE);
        wr(MCR_OFF_CLR, 32'h00003f0f, MCR_SIZE_BYTE);
        rdc(MCR_OFF_CFG, 32'h00001205);
        // halfword read returns the whole word, byte read returns zero
        acc(1'b0, MCR_OFF_CFG, MCR_SIZE_HALF, 32'h0, rd);
        chk(rd, 32'h00001205);
        acc(1'b0, MCR_OFF_CFG, MCR_SIZE_BYTE, 32'h0, rd);
        chk(rd, 32'h0);
    endtask

    // window of 4 bytes: collision after byte 4 is late
    task automatic t_window();
        logic [31:0] r0, l0, w0;
        wr(MCR_OFF_CFG, 32'h00000403, MCR_SIZE_WORD);
        r0 = n_ret;
        l0 = n_late;
        w0 = n_win;
        frame(4, 1'b1);
        chk(n_late - l0, 32'h1);
        chk(n_win - w0, 32'h3);
        // single-byte frame: the start byte alone opens the window
        frame(1, 1'b0);
        chk(n_win - w0, 32'h4);
        frame(3, 1'b0);
        frame(3, 1'b1);
        chk(n_ret - r0, 32'h1);
        chk(n_late - l0, 32'h1);
        frame(3, 1'b0);
    endtask

    // limit 2: two retries then abort; limit 0 aborts at once
    task automatic t_retry();
        logic [31:0] r0, a0;
        wr(MCR_OFF_CFG, 32'h00003702, MCR_SIZE_WORD);
        r0 = n_ret;
        a0 = n_abt;
        repeat (3) frame(3, 1'b1);
        chk(n_ret - r0, 32'h2);
        chk(n_abt - a0, 32'h1);
        wr(MCR_OFF_CFG, 32'h00003700, MCR_SIZE_WORD);
        frame(3, 1'b1);
        chk(n_ret - r0, 32'h2);
        chk(n_abt - a0, 32'h2);
        // sticky abort and late flags, abort flag cleared by writing one
        rdc(MCR_OFF_STAT, 32'h00000600);
        wr(MCR_OFF_STAT, 32'h00000200, MCR_SIZE_WORD);
        rdc(MCR_OFF_STAT, 32'h00000400);
    endtask

    // mid-run reset brings the fields back to their defaults
    task automatic t_rereset();
        wr(MCR_OFF_CFG, 32'h00000000, MCR_SIZE_WORD);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rdc(MCR_OFF_CFG, 32'h0000370f);
        rdc(MCR_OFF_STAT, 32'h0);
    endtask

    // ========================================
    // closing and sequence
    // ========================================
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // watchdog, far beyond the about 160 cycles needed
    initial begin
        #200us;
        err_total++;
        end_of_test();
    end

    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_reset();
        t_word();
        t_alias();
        t_sizes();
        t_window();
        t_retry();
        t_rereset();
        end_of_test();
    end
endmodule
